//--- core/prl_pkg.sv
`default_nettype none
package prl_pkg;
  localparam int NPORT       = 9;
  localparam int PORTW       = 4;
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
  localparam int STRAP_WAIT  = 3;
  localparam int SIZE_SHIFT  = 13;
  localparam int BYTE_SHIFT  = 3;
  localparam int IDX_LSB     = 2;

  localparam logic [11:0] A_GLOBAL  = 12'h000;
  localparam logic [11:0] A_STATUS  = 12'h004;
  localparam logic [11:0] A_RXRATE  = 12'h100;
  localparam logic [11:0] A_RXCFG   = 12'h200;
  localparam logic [11:0] A_EGRESS  = 12'h300;
  localparam logic [11:0] A_BLK_MSK = 12'hf00;
  localparam logic [11:0] A_OFF_MSK = 12'h0ff;
  localparam logic [11:0] A_IDX_MSK = 12'h03c;

  localparam logic [7:0]  RC_LO_MAX  = 8'h1c;
  localparam logic [7:0]  RC_MID_MAX = 8'h7f;
  localparam logic [7:0]  RC_MID_OFF = 8'h1b;
  localparam logic [7:0]  RC_HI_OFF  = 8'h73;
  localparam logic [19:0] K_LO       = 20'h00040;
  localparam logic [19:0] K_MID      = 20'h003e8;
  localparam logic [19:0] K_HI       = 20'h01f40;
  localparam logic [19:0] K_S10      = 20'h00050;
  localparam logic [19:0] K_S100     = 20'h00320;
  localparam logic [19:0] K_S200     = 20'h00640;
  localparam logic [19:0] K_S1000    = 20'h01f40;

  typedef enum logic [1:0] {
    SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_200 = 2'h2, SPD_1000 = 2'h3
  } prl_speed_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_GLOBAL = 3'h1, K_STATUS = 3'h2, K_RXRATE = 3'h3, K_RXCFG = 3'h4, K_EGRESS = 3'h5
  } prl_kind_t;

  typedef struct packed {
    logic [PORTW-1:0] port;
    logic [2:0]       ptype;
    logic [13:0]      len;
  } prl_frame_t;

  typedef struct packed { logic fc_mode; logic scaled; } prl_glob_t;
  typedef struct packed { logic en; logic [7:0] rc1; logic [7:0] rc0; } prl_rxrate_t;
  typedef struct packed { logic [7:0] size1; logic [7:0] size0; logic [7:0] mask1; logic [7:0] mask0; } prl_rxcfg_t;
  typedef struct packed { logic packets_per_second_limit; logic en; logic [7:0] size; logic [7:0] rc; } prl_egr_t;

  localparam prl_glob_t   GLOB_RST = '0;
  localparam prl_rxrate_t RR_RST   = '0;
  localparam prl_rxcfg_t  RC_RST   = '0;
  localparam prl_egr_t    EG_RST   = '0;

  // Bucket rate in kbit/s, which is also bits per 1 ms tick
  function automatic logic [19:0] prl_rate(input logic [7:0] rc, input logic scaled, input prl_speed_t sp);
    logic [19:0] r;
    r = {12'h000, rc};
    if (scaled) begin
      unique case (sp)
        SPD_10:   r = r * K_S10;
        SPD_100:  r = r * K_S100;
        SPD_200:  r = r * K_S200;
        SPD_1000: r = r * K_S1000;
      endcase
    end else if (rc <= RC_LO_MAX) begin
      r = r * K_LO;
    end else if (rc <= RC_MID_MAX) begin
      r = {12'h000, rc - RC_MID_OFF} * K_MID;
    end else begin
      r = {12'h000, rc - RC_HI_OFF} * K_HI;
    end
    return r;
  endfunction

  function automatic logic [31:0] prl_cap(input logic [7:0] size, input logic packets_per_second_limit);
    return packets_per_second_limit ? 32'(size) : (32'(size) << SIZE_SHIFT);
  endfunction

  function automatic logic [31:0] prl_bits(input logic [13:0] len);
    return 32'(len) << BYTE_SHIFT;
  endfunction

  // Deduct then refill with saturation at the bucket size
  function automatic logic [31:0] prl_step(input logic [31:0] cur, input logic take, input logic [31:0] need,
                                           input logic tick, input logic [19:0] rate, input logic [31:0] cap);
    logic [31:0] c;
    logic [32:0] s;
    c = cur;
    s = '0;
    if (take) c = c - ((c < need) ? c : need);
    if (tick) begin
      s = {1'b0, c} + 33'(rate);
      c = (s > {1'b0, cap}) ? cap : s[31:0];
    end
    return c;
  endfunction
endpackage
`default_nettype wire

//--- core/prl_port_rate_limiter.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Drop monitored ingress frames above rate
// - Strap or register enables ingress suppression
// - Buckets refill at programmed bit rate
// - Monitored received frames drain bucket credit
// - Credit saturates at programmed bucket size
// - Empty bucket: drop or flow control
// - Two ingress buckets, own type masks
// - Per-port rate count and size per bucket
// - Per-port ingress suppression enable
// - Chip-wide mode scales rate with speed
// - Absolute rate equations by count range
// - Scaled rate equations by link speed
// - One egress bucket per port, all traffic
// - One egress register per port configures it
// - Egress uses absolute rate equations only
// - Management port offers packets-per-second limit
module prl_port_rate_limiter
  import prl_pkg::*;
#(
  parameter int NP   = NPORT,
  parameter int TICK = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // APB slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic            pready,
  output logic            pslverr,
  // Strap pin
  input  wire logic       storm_suppress_strap,
  // Link speed per port
  input  wire prl_speed_t link_speed [NP],
  // Ingress frame events
  input  wire logic       ing_valid,
  input  wire prl_frame_t ing_frame,
  output logic            ing_done,
  output logic            ing_drop,
  output logic [NP-1:0]   fc_pause,
  // Egress frame events
  input  wire logic       egr_valid,
  input  wire prl_frame_t egr_frame,
  output logic            egr_done,
  output logic            egr_hold
);
  localparam int MANAGEMENT_PORT = NP - 1;
  localparam int NIB = 2;
  localparam int DW  = $clog2(TICK + 1);
  localparam logic [DW-1:0]    DIV_LAST  = DW'(TICK - 1);
  localparam logic [1:0]       WAIT_LAST = 2'(STRAP_WAIT);
  localparam logic [PORTW-1:0] NP_W      = PORTW'(NP);

  prl_glob_t   glob_reg;
  prl_rxrate_t rr_reg [NP];
  prl_rxcfg_t  rc_reg [NP];
  prl_egr_t    eg_reg [NP];
  logic [31:0] cred_reg  [NIB][NP];
  logic [31:0] cred_next [NIB][NP];
  logic [31:0] ecred_reg  [NP];
  logic [31:0] ecred_next [NP];
  logic [19:0] rate  [NIB][NP];
  logic [31:0] cap   [NIB][NP];
  logic [19:0] erate [NP];
  logic [31:0] ecap  [NP];
  logic [DW-1:0] div_reg;
  logic          tick;
  logic [2:0]    strap_sync_reg;
  logic [1:0]    wait_reg;
  logic          strap_done_reg;
  logic          strap_take;
  logic [NP-1:0] pause_reg;
  logic [NP-1:0] egr_zero;
  logic [NP-1:0] rx_en_vec;
  prl_kind_t        kind;
  logic [PORTW-1:0] a_idx;
  logic             wr;
  logic [31:0]      rd_val;
  logic [PORTW-1:0] ip;
  logic [PORTW-1:0] ep;
  logic             iv;
  logic             ev;
  logic [31:0]      ibits;
  logic [31:0]      eneed;
  logic [NIB-1:0]   mon;
  logic [NIB-1:0]   shrt;
  logic             over;
  logic             drop_now;
  logic             een;
  logic             epps;
  logic             ehold;

  // Register decode shared by read, write and error answer
  function automatic prl_kind_t dec_kind(input logic [11:0] a);
    logic [PORTW-1:0] i;
    logic             ok;
    i = a[IDX_LSB +: PORTW];
    ok = ((a & A_OFF_MSK) == (a & A_IDX_MSK)) && (i < NP_W);
    dec_kind = K_NONE;
    if (a == A_GLOBAL) dec_kind = K_GLOBAL;
    else if (a == A_STATUS) dec_kind = K_STATUS;
    else if (ok && (a & A_BLK_MSK) == A_RXRATE) dec_kind = K_RXRATE;
    else if (ok && (a & A_BLK_MSK) == A_RXCFG) dec_kind = K_RXCFG;
    else if (ok && (a & A_BLK_MSK) == A_EGRESS) dec_kind = K_EGRESS;
  endfunction

  // 1 ms refill tick
  assign tick = (div_reg == DIV_LAST);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_reg <= '0;
    else if (tick) div_reg <= '0;
    else div_reg <= div_reg + 1'b1;
  end

  // Strap synchroniser and one capture after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_sync_reg <= '0;
      wait_reg       <= '0;
      strap_done_reg <= 1'b0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[1:0], storm_suppress_strap};
      if (wait_reg != WAIT_LAST) wait_reg <= wait_reg + 1'b1;
      if (strap_take) strap_done_reg <= 1'b1;
    end
  end
  assign strap_take = !strap_done_reg && (wait_reg == WAIT_LAST) && (strap_sync_reg[1] == strap_sync_reg[2]);

  // APB: zero wait states, read data latched in the setup cycle
  assign kind    = dec_kind(paddr);
  assign a_idx   = paddr[IDX_LSB +: PORTW];
  assign pready  = psel & penable;
  assign pslverr = pready & (kind == K_NONE);
  assign wr      = pready & pwrite & (kind != K_NONE);

  always_comb begin
    unique case (kind)
      K_GLOBAL: rd_val = 32'(glob_reg);
      K_STATUS: rd_val = 32'({strap_done_reg, egr_zero, pause_reg});
      K_RXRATE: rd_val = 32'(rr_reg[a_idx]);
      K_RXCFG:  rd_val = 32'(rc_reg[a_idx]);
      K_EGRESS: rd_val = 32'(eg_reg[a_idx]);
      default:  rd_val = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) prdata <= '0;
    else if (psel && !penable && !pwrite) prdata <= rd_val;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      glob_reg <= GLOB_RST;
      for (int p = 0; p < NP; p++) begin
        rr_reg[p] <= RR_RST;
        rc_reg[p] <= RC_RST;
        eg_reg[p] <= EG_RST;
      end
    end else begin
      if (wr && kind == K_GLOBAL) glob_reg <= prl_glob_t'(pwdata[$bits(prl_glob_t)-1:0]);
      for (int p = 0; p < NP; p++) begin
        if (strap_take) rr_reg[p].en <= strap_sync_reg[2];
        else if (wr && kind == K_RXRATE && a_idx == PORTW'(p))
          rr_reg[p] <= prl_rxrate_t'(pwdata[$bits(prl_rxrate_t)-1:0]);
        if (wr && kind == K_RXCFG && a_idx == PORTW'(p))
          rc_reg[p] <= prl_rxcfg_t'(pwdata[$bits(prl_rxcfg_t)-1:0]);
        if (wr && kind == K_EGRESS && a_idx == PORTW'(p))
          eg_reg[p] <= prl_egr_t'(pwdata[$bits(prl_egr_t)-1:0]);
      end
    end
  end

  // Rates and sizes of every bucket
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      rate[0][p] = prl_rate(rr_reg[p].rc0, glob_reg.scaled, link_speed[p]);
      rate[1][p] = prl_rate(rr_reg[p].rc1, glob_reg.scaled, link_speed[p]);
      cap[0][p]  = prl_cap(rc_reg[p].size0, 1'b0);
      cap[1][p]  = prl_cap(rc_reg[p].size1, 1'b0);
      if (p == MANAGEMENT_PORT && eg_reg[p].packets_per_second_limit) begin
        erate[p] = 20'(eg_reg[p].rc);
        ecap[p]  = prl_cap(eg_reg[p].size, 1'b1);
      end else begin
        erate[p] = prl_rate(eg_reg[p].rc, 1'b0, link_speed[p]);
        ecap[p]  = prl_cap(eg_reg[p].size, 1'b0);
      end
      rx_en_vec[p] = rr_reg[p].en;
      egr_zero[p]  = (ecred_reg[p] == '0);
    end
  end

  // Ingress decision
  assign ip    = ing_frame.port;
  assign iv    = ing_valid && (ip < NP_W);
  assign ibits = prl_bits(ing_frame.len);
  assign mon[0] = iv && rr_reg[ip].en && rc_reg[ip].mask0[ing_frame.ptype];
  assign mon[1] = iv && rr_reg[ip].en && rc_reg[ip].mask1[ing_frame.ptype];
  assign shrt[0] = mon[0] && (cred_reg[0][ip] < ibits);
  assign shrt[1] = mon[1] && (cred_reg[1][ip] < ibits);
  assign over     = |shrt;
  assign drop_now = over && !glob_reg.fc_mode;

  // Egress decision
  assign ep    = egr_frame.port;
  assign ev    = egr_valid && (ep < NP_W);
  assign een   = ev && eg_reg[ep].en;
  assign epps  = (ep == PORTW'(MANAGEMENT_PORT)) && eg_reg[ep].packets_per_second_limit;
  assign eneed = epps ? 32'h0000_0001 : prl_bits(egr_frame.len);
  assign ehold = een && (ecred_reg[ep] < eneed);

  always_comb begin
    for (int p = 0; p < NP; p++) begin
      for (int b = 0; b < NIB; b++) begin
        cred_next[b][p] = prl_step(cred_reg[b][p], iv && !drop_now && mon[b] && ip == PORTW'(p),
                                   ibits, tick, rate[b][p], cap[b][p]);
      end
      ecred_next[p] = prl_step(ecred_reg[p], een && !ehold && ep == PORTW'(p),
                               eneed, tick, erate[p], ecap[p]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < NP; p++) begin
        cred_reg[0][p] <= '0;
        cred_reg[1][p] <= '0;
        ecred_reg[p]   <= '0;
      end
    end else begin
      cred_reg  <= cred_next;
      ecred_reg <= ecred_next;
    end
  end

  // Answers one cycle after each event
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ing_done <= 1'b0;
      ing_drop <= 1'b0;
      egr_done <= 1'b0;
      egr_hold <= 1'b0;
    end else begin
      ing_done <= ing_valid;
      ing_drop <= ing_valid && drop_now;
      egr_done <= egr_valid;
      egr_hold <= ehold;
    end
  end

  // Pause request per port; a new excess frame wins over the tick clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pause_reg <= '0;
    else begin
      for (int p = 0; p < NP; p++) begin
        if (iv && over && glob_reg.fc_mode && ip == PORTW'(p)) pause_reg[p] <= 1'b1;
        else if (tick) pause_reg[p] <= 1'b0;
      end
    end
  end
  assign fc_pause = pause_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_excess;
    iv && over && !glob_reg.fc_mode;
  endsequence
  sequence s_fc_excess;
    iv && over && glob_reg.fc_mode;
  endsequence

  a_drop_excess: assert property (s_excess |=> ing_done && ing_drop)
    else $error("excess frame not dropped");
  a_pass_credit: assert property (ing_valid && !over |=> !ing_drop)
    else $error("frame with credit dropped");
  a_fc_pause: assert property (s_fc_excess |=> !ing_drop && fc_pause[$past(ip)])
    else $error("flow control mode did not pause");
  a_disabled_pass: assert property (iv && !rr_reg[ip].en |=> !ing_drop)
    else $error("disabled port dropped frame");
  a_refill_rate: assert property (tick && !(iv && ip == '0) && (33'(cred_reg[0][0]) + 33'(rate[0][0]) < 33'(cap[0][0]))
                                  |=> cred_reg[0][0] == $past(cred_reg[0][0]) + 32'($past(rate[0][0])))
    else $error("bucket refill wrong");
  a_cap_saturate: assert property (tick && !(iv && ip == '0) && (33'(cred_reg[0][0]) + 33'(rate[0][0]) >= 33'(cap[0][0]))
                                   |=> cred_reg[0][0] == $past(cap[0][0]))
    else $error("bucket did not saturate");
  a_deduct_len: assert property (!tick && iv && ip == '0 && mon[1] && !over
                                 |=> cred_reg[1][0] == $past(cred_reg[1][0]) - $past(ibits))
    else $error("credit not deducted by frame length");
  a_egress_hold: assert property (een && ecred_reg[ep] < eneed |=> egr_done && egr_hold)
    else $error("egress excess not held");
  a_pps_unit: assert property (een && epps && ecred_reg[ep] != '0 |=> !egr_hold)
    else $error("packet mode held with credit");
  a_strap_apply: assert property ($rose(strap_done_reg) |-> rx_en_vec == {NP{$past(strap_sync_reg[2])}})
    else $error("strap not applied to enables");
endmodule
`default_nettype wire

//--- dv/prl_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module prl_mac_model
  import prl_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Receive events
  output logic            ing_valid,
  output prl_frame_t      ing_frame,
  input  wire logic       ing_done,
  input  wire logic       ing_drop,
  // Transmit events
  output logic            egr_valid,
  output prl_frame_t      egr_frame,
  input  wire logic       egr_done,
  input  wire logic       egr_hold
);
  initial begin
    ing_valid = 1'b0;
    egr_valid = 1'b0;
    ing_frame = '0;
    egr_frame = '0;
  end

  // One frame event; answer taken one cycle after the event
  task automatic send(input logic egr, input prl_frame_t f, output logic [1:0] res);
    @(posedge clk);
    ing_valid <= ~egr;
    egr_valid <= egr;
    ing_frame <= f;
    egr_frame <= f;
    @(posedge clk);
    ing_valid <= 1'b0;
    egr_valid <= 1'b0;
    // Frame fields are stale now: show a changing pattern
    ing_frame <= ~f;
    egr_frame <= ~f;
    #1;
    res = egr ? {egr_done, egr_hold} : {ing_done, ing_drop};
  endtask
endmodule
`default_nettype wire

//--- dv/tb_port_rate_limiter.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) \
  begin tests_run++; if ((g) !== (x)) begin \
    n_mismatch++; $display("MISMATCH %0t got %0h exp %0h", $time, (g), (x)); end end
module tb_port_rate_limiter;
  import prl_pkg::*;
  localparam int TK    = 20;
  localparam int LIMIT = 20000;
  logic             clk, rst, strap;
  logic             psel, penable, pwrite, pready, pslverr;
  logic [11:0]      paddr;
  logic [31:0]      pwdata, prdata;
  prl_speed_t       link_speed [NPORT];
  logic             ing_valid, ing_done, ing_drop, egr_valid, egr_done, egr_hold;
  prl_frame_t       ing_frame, egr_frame;
  logic [NPORT-1:0] fc_pause;
  int               n_mismatch, tests_run, cyc, tph, seed;

  always #50 clk = ~clk;

  prl_port_rate_limiter #(.NP(NPORT), .TICK(TK)) prl_port_rate_limiter_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .storm_suppress_strap(strap), .link_speed(link_speed), .ing_valid(ing_valid),
    .ing_frame(ing_frame), .ing_done(ing_done), .ing_drop(ing_drop), .fc_pause(fc_pause),
    .egr_valid(egr_valid), .egr_frame(egr_frame), .egr_done(egr_done), .egr_hold(egr_hold));

  prl_mac_model prl_mac_model_inst (
    .clk(clk), .ing_valid(ing_valid), .ing_frame(ing_frame), .ing_done(ing_done),
    .ing_drop(ing_drop), .egr_valid(egr_valid), .egr_frame(egr_frame), .egr_done(egr_done),
    .egr_hold(egr_hold));

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end

  function automatic int rnd(int n);
    return $unsigned($random(seed)) % n;
  endfunction

  // Bits credited per refill tick
  function automatic int exp_rate(int rc, logic sc, int sp);
    if (sc) return rc * 8000 / (sp == 0 ? 100 : sp == 1 ? 10 : sp == 2 ? 5 : 1);
    if (rc <= 28) return rc * 64;
    if (rc <= 127) return (rc - 27) * 1000;
    return (rc - 115) * 8000;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) n_mismatch++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic frame(input logic egr, input int p, input int pt, input int len, input logic blk);
    logic [1:0] r;
    prl_frame_t f;
    f = '{port: 4'(p), ptype: 3'(pt), len: 14'(len)};
    prl_mac_model_inst.send(egr, f, r);
    `CHK(r, {1'b1, blk})
  endtask

  // Returns one cycle after a refill tick
  task automatic wait_tick();
    do begin
      @(posedge clk);
      #1;
    end while ((cyc - tph) % TK != 0);
  endtask

  task automatic run_case(input logic egr, input int p, input int rc, input logic sc, input int sp,
                          input logic packets_per_second_limit);
    int          r;
    logic [11:0] a;
    r = packets_per_second_limit ? rc : exp_rate(rc, sc & ~egr, sp);
    a = 12'(4 * p);
    @(posedge clk);
    link_speed[p] <= prl_speed_t'(sp);
    wr(A_GLOBAL, {31'h0, sc});
    if (egr) begin
      wr(A_EGRESS + a, {14'h0, packets_per_second_limit, 1'b1, 8'h00, 8'(rc)});
    end else begin
      wr(A_RXRATE + a, {15'h0, 1'b1, 8'h00, 8'(rc)});
      wr(A_RXCFG + a, 32'h0000807f);
    end
    // Zero-size bucket forces credit to zero at a tick
    wait_tick();
    wait_tick();
    if (egr) wr(A_EGRESS + a, {14'h0, packets_per_second_limit, 1'b1, 8'hff, 8'(rc)});
    else wr(A_RXCFG + a, 32'h00ff807f);
    wait_tick();
    if (!egr) frame(1'b0, p, 7, 1, 1'b1);
    if (packets_per_second_limit) begin
      repeat (r) frame(1'b1, p, rnd(8), rnd(100) + 1, 1'b0);
      frame(1'b1, p, 0, 1, 1'b1);
    end else begin
      frame(egr, p, rnd(7), r / 8 + 1, 1'b1);
      frame(egr, p, rnd(7), r / 8, 1'b0);
      frame(egr, p, rnd(7), 1, 1'b1);
    end
    if (!egr) begin
      wr(A_RXRATE + a, 32'h0);
      frame(1'b0, p, 7, 1, 1'b0);
    end
  endtask

  int cs [14][4] = '{'{1, 0, 0, 0}, '{28, 0, 3, 0}, '{29, 0, 1, 0}, '{127, 0, 0, 0}, '{128, 0, 2, 0},
                     '{131, 0, 3, 0}, '{1, 1, 0, 0}, '{125, 1, 0, 0}, '{125, 1, 1, 0}, '{81, 1, 2, 0},
                     '{16, 1, 3, 0}, '{29, 1, 0, 1}, '{131, 1, 3, 1}, '{1, 1, 2, 1}};

  initial begin
    logic [31:0] q, d;
    logic        e;
    int          p;
    seed = 23;
    clk = 1'b0;
    rst = 1'b1;
    strap = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    foreach (link_speed[i]) link_speed[i] = SPD_1000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b0, A_RXRATE + 12'h00c, '0, q, e);
    `CHK(q, 32'h00010000)
    apb(1'b0, A_STATUS, '0, q, e);
    `CHK(q, 32'h0007fe00)
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, i ? 12'h124 : 12'h400, '0, q, e);
      `CHK({e, q}, 33'h100000000)
    end
    d = $random(seed);
    p = rnd(NPORT);
    wr(A_RXCFG + 12'(4 * p), d);
    apb(1'b0, A_RXCFG + 12'(4 * p), '0, q, e);
    `CHK(q, d)
    // Flow-control mode: short frame passes, pause flag marks the tick phase
    wr(A_GLOBAL, 32'h2);
    wr(A_RXCFG, 32'h000000ff);
    repeat (2 * TK) @(posedge clk);
    frame(1'b0, 0, 1, 1, 1'b0);
    `CHK(fc_pause[0], 1'b1)
    for (int k = 0; k < 3 * TK && fc_pause[0] === 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    tph = cyc;
    `CHK(fc_pause[0], 1'b0)
    // Port 0, both buckets at rate count 28: a type 7 frame drains only bucket 1
    wr(A_GLOBAL, 32'h0);
    wr(A_RXRATE, 32'h00011c1c);
    wr(A_RXCFG, 32'hffff807f);
    wait_tick();
    frame(1'b0, 0, 7, exp_rate(28, 1'b0, 0) / 8, 1'b0);
    frame(1'b0, 0, 7, 1, 1'b1);
    frame(1'b0, 0, 0, exp_rate(28, 1'b0, 0) / 8, 1'b0);
    for (int i = 0; i < 14; i++) begin
      run_case(cs[i][3], rnd(cs[i][3] ? 8 : NPORT), cs[i][0], cs[i][1], cs[i][2], 1'b0);
    end
    repeat (4) run_case(1'b0, rnd(NPORT), 29 + rnd(99), 1'b0, rnd(4), 1'b0);
    run_case(1'b1, NPORT - 1, 2, 1'b0, 0, 1'b1);
    // Second reset with the strap low: no port comes back enabled
    @(posedge clk);
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    p = rnd(NPORT);
    apb(1'b0, A_RXRATE + 12'(4 * p), '0, q, e);
    `CHK(q, 32'h00000000)
    apb(1'b0, A_STATUS, '0, q, e);
    `CHK(q, 32'h0007fe00)
    give_verdict();
  end
endmodule
`default_nettype wire
